/* File: hsp_asserts.sv */
// port checker for the host serial packetizer
`timescale 1ns/1ps
`default_nettype none
module hsp_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pins
  input wire logic host_txd_o,
  input wire logic configurable_input_pin_i,
  input wire logic binary_cmd_o,
  // radio stream
  input wire logic [7:0] radio_data_o,
  input wire logic radio_valid_o,
  input wire logic radio_last_o,
  input wire logic radio_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bytes already taken in the current packet
  logic [8:0] n;
  always_ff @(posedge clk_i) begin
    if (rst_i) n <= 9'h000;
    else if (radio_valid_o && radio_ready_i) n <= radio_last_o ? 9'h000 : n + 9'h001;
  end
  ack_rise_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  stream_hold_a: assert property (radio_valid_o && !radio_ready_i |=>
    radio_valid_o && $stable(radio_data_o) && $stable(radio_last_o))
    else $error("radio byte dropped while stalled");
  pkt_size_a: assert property (radio_valid_o && radio_ready_i && n == 9'h0ff |-> radio_last_o)
    else $error("radio packet above 256 bytes");
  bin_cmd_a: assert property ($rose(binary_cmd_o) |-> $past(configurable_input_pin_i))
    else $error("binary command without input pin");
  start_bit_a: assert property ($fell(host_txd_o) |-> !host_txd_o [*8])
    else $error("short start bit to host");
  reset_quiet_a: assert property ($fell(rst_i) |-> !radio_valid_o && host_txd_o && !wb_ack_o)
    else $error("activity right after reset");
endmodule : hsp_asserts
bind hsp_top hsp_asserts hsp_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .host_txd_o(host_txd_o),
  .configurable_input_pin_i(configurable_input_pin_i), .binary_cmd_o(binary_cmd_o),
  .radio_data_o(radio_data_o), .radio_valid_o(radio_valid_o), .radio_last_o(radio_last_o),
  .radio_ready_i(radio_ready_i));
`default_nettype wire

/* File: hsp_bench.sv */
// self-checking bench for the host serial packetizer
`timescale 1ns/1ps
`default_nettype none
module hsp_bench;
  import hsp_pkg::*;
  localparam int BIT = 1736;
  logic clk = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic pin = 1'b0;
  logic rdy = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [3:0] lanes = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rxd, host_txd_o, flow_output_pin_o, binary_cmd_o;
  logic [7:0] radio_data_o;
  logic radio_valid_o, radio_last_o;
  logic [8:0] rq[$];
  int fails = 0;
  int compares = 0;
  // short silence unit keeps the run brief
  hsp_top #(.SILENCE_UNIT(20)) hsp_top_inst (.clk_i(clk), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .host_rxd_i(rxd), .host_txd_o(host_txd_o),
    .flow_output_pin_o(flow_output_pin_o), .configurable_input_pin_i(pin),
    .radio_data_o(radio_data_o), .radio_valid_o(radio_valid_o), .radio_last_o(radio_last_o),
    .radio_ready_i(rdy), .binary_cmd_o(binary_cmd_o));
  hsp_host #(.BIT(BIT)) hsp_host_inst (.clk_i(clk), .cts_n_i(flow_output_pin_o),
    .dev_txd_i(host_txd_o), .host_txd_o(rxd));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (radio_valid_o === 1'b1 && rdy === 1'b1) rq.push_back({radio_last_o, radio_data_o});
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic rw(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rd(a, e);
  endtask : rw
  task automatic t_regs;
    rd(ADDR_CFG, 32'h0);
    rd(ADDR_MAX_PKT, 32'h40);
    rd(ADDR_CHAR_THR, 32'h1);
    rd(ADDR_SILENCE, 32'h0);
    rd(ADDR_BAUD, 32'(BAUD_RST));
    rd(ADDR_FLOW_THR, 32'd239);
    rd(8'h1c, 32'h0);
    chk(32'(flow_output_pin_o), 32'h0);
    for (int p = 0; p < 7; p++) rw(ADDR_CFG, p << 4, (p > 5 ? 5 : p) << 4);
    for (int b = 0; b < 8; b++) rw(ADDR_BAUD, b, b > 6 ? 6 : b);
    for (int i = 0; i < 4; i++) rw(ADDR_CFG, i << 8, (i > 2 ? 2 : i) << 8);
    rw(ADDR_CFG, 32'h100, 32'h100);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(binary_cmd_o), 32'h1);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(binary_cmd_o), 32'h0);
    rw(ADDR_CFG, 32'h2000, 32'h2000);
    chk(32'(flow_output_pin_o), 32'h1);
    rw(ADDR_CFG, 32'h5000, 32'h2000);
    rw(ADDR_CFG, 32'h1, 32'h1);
    rw(ADDR_SILENCE, 32'hffff, 32'hffff);
    lanes = 4'h2;
    wr(ADDR_SILENCE, 32'h0);
    lanes = 4'hf;
    rd(ADDR_SILENCE, 32'hff);
    rw(ADDR_FLOW_THR, 32'hff, 32'd239);
    rw(ADDR_MAX_PKT, 32'h1, 32'h2);
    rw(ADDR_MAX_PKT, 32'h1ff, 32'h100);
    rw(ADDR_CHAR_THR, 32'h0, 32'h1);
    rw(ADDR_CHAR_THR, 32'h100, 32'h100);
    wr(ADDR_MAX_PKT, 32'h4);
    rd(ADDR_CHAR_THR, 32'h4);
  endtask : t_regs
  task automatic t_pkts;
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_SILENCE, 32'h0);
    wr(ADDR_BAUD, 32'h6);
    wr(ADDR_MAX_PKT, 32'h2);
    rdy <= 1'b1;
    hsp_host_inst.send(8'ha5);
    hsp_host_inst.send(8'h3c);
    hsp_host_inst.send(8'h7e);
    repeat (100) @(posedge clk);
    chk(rq.size(), 2);
    wr(ADDR_SILENCE, 32'h1);
    repeat (100) @(posedge clk);
    chk(rq.size(), 3);
    chk(rq[0], 9'h0a5);
    chk(rq[1], 9'h13c);
    chk(rq[2], 9'h17e);
  endtask : t_pkts
  task automatic t_flow;
    rdy <= 1'b0;
    wr(ADDR_SILENCE, 32'h0);
    wr(ADDR_MAX_PKT, 32'h4);
    wr(ADDR_CHAR_THR, 32'h4);
    wr(ADDR_FLOW_THR, 32'h1);
    wr(ADDR_CFG, 32'h1);
    chk(32'(flow_output_pin_o), 32'h0);
    hsp_host_inst.send(8'h01);
    repeat (20) @(posedge clk);
    chk(32'(flow_output_pin_o), 32'h1);
    rd(ADDR_STATUS, 32'h20001);
    wr(ADDR_FLOW_THR, 32'd18);
    rd(ADDR_STATUS, 32'h10001);
    chk(32'(flow_output_pin_o), 32'h0);
    repeat (9 * BIT) @(posedge clk);
    chk(hsp_host_inst.got.size(), 1);
    chk(hsp_host_inst.got[0], CHAR_PAUSE);
  endtask : t_flow
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge clk);
    rst_i <= 1'b0;
    t_regs();
    t_pkts();
    t_flow();
    end_sim();
  end
  // four characters in, one out, plus bus traffic: about 86000 cycles
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : hsp_bench
`default_nettype wire

/* File: hsp_host.sv */
// host uart model: 8n1 sender gated by cts, receiver for control chars
`timescale 1ns/1ps
`default_nettype none
module hsp_host #(
  parameter int BIT = 1736
) (
  // clock
  input wire logic clk_i,
  // device pins
  input wire logic cts_n_i,
  input wire logic dev_txd_i,
  output logic host_txd_o
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial host_txd_o = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // a byte already started is finished, as a real uart does
    while (cts_n_i !== 1'b0) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      host_txd_o <= f[i]; // lsb first, no parity
      repeat (BIT) @(posedge clk_i);
    end
  endtask : send
  always begin
    @(negedge dev_txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      sh[i] = dev_txd_i;
    end
    got.push_back(sh);
    repeat (BIT) @(posedge clk_i);
  end
endmodule : hsp_host
`default_nettype wire

/* File: hsp_pkg.sv */
// package for the host serial packetizer: register map, fields, timing
package hsp_pkg;
  // wishbone word offsets (byte addresses)
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_FLOW_THR = 8'h04;
  localparam logic [7:0] ADDR_MAX_PKT = 8'h08;
  localparam logic [7:0] ADDR_CHAR_THR = 8'h0c;
  localparam logic [7:0] ADDR_SILENCE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_BAUD = 8'h18;
  // cfg register fields
  localparam int CFG_SWFLOW_BIT = 0;
  localparam int CFG_PARITY_LSB = 4;
  localparam int CFG_INLINE_LSB = 8;
  localparam int CFG_OUTPIN_LSB = 12;
  // control characters
  localparam logic [7:0] CHAR_RESUME = 8'h11;
  localparam logic [7:0] CHAR_PAUSE = 8'h13;
  // parity encodings
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  localparam logic [2:0] PAR_NINE = 3'h5;
  // input line config
  localparam logic [1:0] INLINE_OFF = 2'h0;
  localparam logic [1:0] INLINE_BINCMD = 2'h1;
  localparam logic [1:0] INLINE_RTS = 2'h2;
  // reset values and limits
  localparam logic [8:0] MAX_PKT_RST = 9'h040;
  localparam logic [8:0] MAX_PKT_MIN = 9'h002;
  localparam logic [8:0] PKT_LIMIT = 9'h100;
  localparam logic [8:0] CHAR_THR_RST = 9'h001;
  localparam logic [15:0] SILENCE_RST = 16'h0000;
  localparam logic [2:0] BAUD_RST = 3'h3;
  localparam logic [2:0] BAUD_MAX = 3'h6;
  localparam int FLOW_HYST = 16;
  localparam int FLOW_MARGIN = 17;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SILENCE_UNIT_US = 200;
  localparam int SILENCE_UNIT_CYC = CLK_HZ / 1_000_000 * SILENCE_UNIT_US;
  localparam int BAUD_1200_CYC = CLK_HZ / 1200;
  localparam int BAUD_57600_CYC = CLK_HZ / 57600;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } hsp_wb_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } hsp_byte_t;
endpackage : hsp_pkg

/* File: hsp_top.sv */
// host serial packetizer: uart framing, flow control, packet triggers
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hsp_top #(
  parameter int BUF_DEPTH = 256,
  parameter int SILENCE_UNIT = hsp_pkg::SILENCE_UNIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // host serial pins
  input wire logic host_rxd_i,
  output logic host_txd_o,
  output logic flow_output_pin_o,
  input wire logic configurable_input_pin_i,
  // radio side packet stream
  output logic [7:0] radio_data_o,
  output logic radio_valid_o,
  output logic radio_last_o,
  input wire logic radio_ready_i,
  output logic binary_cmd_o
);
  import hsp_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [AW:0] CAP = (AW + 1)'(BUF_DEPTH);
  localparam logic [AW:0] FT_MAX = (AW + 1)'(BUF_DEPTH - FLOW_MARGIN);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} hsp_rx_e_t;
  typedef enum {PK_WAIT, PK_SEND} hsp_pk_e_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic swflow;
    logic [2:0] parity;
    logic [1:0] inline_cfg;
    logic [2:0] outpin;
    logic [AW:0] flow_thr;
    logic [8:0] max_pkt;
    logic [8:0] char_thr;
    logic [15:0] silence;
    logic [2:0] baud;
    logic [16:0] rx_tick;
    hsp_rx_e_t rx_st;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_perr;
    logic [AW:0] count;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic cts;
    logic paused;
    logic [7:0] pend_char;
    logic pend;
    logic [16:0] tx_tick;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic txd;
    logic [15:0] unit_cnt;
    logic [15:0] quiet;
    hsp_pk_e_t pk_st;
    logic [8:0] pkt_cnt;
    logic [7:0] rdata;
    logic rvalid;
    logic rlast;
    logic flow_pin;
    logic bincmd;
  } hsp_state_t;

  hsp_state_t r, next_r;
  logic [7:0] mem [BUF_DEPTH];

  // baud divider per code, used by both rx and tx; 1200 baud needs 17 bits
  function automatic logic [16:0] baud_div(input logic [2:0] code);
    logic [2:0] c;
    c = (code > BAUD_MAX) ? BAUD_MAX : code;
    if (c == BAUD_MAX) baud_div = 17'(BAUD_57600_CYC);
    else baud_div = 17'(BAUD_1200_CYC >> c);
  endfunction : baud_div

  // parity bit for a data byte under the selected framing
  function automatic logic par_bit(input logic [2:0] p, input logic [7:0] d);
    case (p)
      PAR_EVEN: par_bit = ^d;
      PAR_ODD: par_bit = ~^d;
      PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  logic [16:0] bdiv;
  logic rts_hold;
  logic has_par;
  logic push;
  logic pop;
  logic [AW:0] restart;
  logic [8:0] wv9;
  assign bdiv = baud_div(r.baud);
  // nine-bit mode carries the ninth bit in the parity slot; it is dropped
  assign has_par = (r.parity != PAR_NONE);
  assign restart = (r.flow_thr > (AW + 1)'(FLOW_HYST)) ? r.flow_thr - (AW + 1)'(FLOW_HYST) : '0;
  assign wv9 = (wb_dat_i[15:0] > 16'(PKT_LIMIT)) ? PKT_LIMIT : wb_dat_i[8:0];
  // host rts, active low, holds back flow characters when enabled
  assign rts_hold = (r.inline_cfg == INLINE_RTS) && configurable_input_pin_i;

  always_comb begin
    next_r = r;
    push = 1'b0;
    pop = 1'b0;
    // wishbone: one wait state, ack dropped the cycle after
    next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      next_r.rdat = '0;
      case (wb_adr_i)
        ADDR_CFG: begin
          next_r.rdat[CFG_SWFLOW_BIT] = r.swflow;
          next_r.rdat[CFG_PARITY_LSB +: 3] = r.parity;
          next_r.rdat[CFG_INLINE_LSB +: 2] = r.inline_cfg;
          next_r.rdat[CFG_OUTPIN_LSB +: 3] = r.outpin;
          if (wb_we_i && wb_sel_i[0]) next_r.swflow = wb_dat_i[CFG_SWFLOW_BIT];
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[CFG_PARITY_LSB +: 3] <= PAR_NINE)
            next_r.parity = wb_dat_i[CFG_PARITY_LSB +: 3];
          if (wb_we_i && wb_sel_i[1] && wb_dat_i[CFG_INLINE_LSB +: 2] <= INLINE_RTS)
            next_r.inline_cfg = wb_dat_i[CFG_INLINE_LSB +: 2];
          if (wb_we_i && wb_sel_i[1] && wb_dat_i[CFG_OUTPIN_LSB +: 3] <= 3'h4)
            next_r.outpin = wb_dat_i[CFG_OUTPIN_LSB +: 3];
        end
        ADDR_FLOW_THR: begin
          next_r.rdat[AW:0] = r.flow_thr;
          if (wb_we_i && wb_sel_i[0])
            next_r.flow_thr = (wb_dat_i[15:0] > 16'(FT_MAX)) ? FT_MAX : wb_dat_i[AW:0];
        end
        ADDR_MAX_PKT: begin
          next_r.rdat[8:0] = r.max_pkt;
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.max_pkt = (wv9 < MAX_PKT_MIN) ? MAX_PKT_MIN : wv9;
            if (r.char_thr > next_r.max_pkt) next_r.char_thr = next_r.max_pkt;
          end
        end
        ADDR_CHAR_THR: begin
          next_r.rdat[8:0] = r.char_thr;
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.char_thr = (wv9 == 9'h000) ? 9'h001 : wv9;
            if (next_r.char_thr > r.max_pkt) next_r.char_thr = r.max_pkt;
          end
        end
        ADDR_SILENCE: begin
          next_r.rdat[15:0] = r.silence;
          if (wb_we_i && wb_sel_i[0]) next_r.silence[7:0] = wb_dat_i[7:0];
          if (wb_we_i && wb_sel_i[1]) next_r.silence[15:8] = wb_dat_i[15:8];
        end
        ADDR_STATUS: begin
          next_r.rdat[AW:0] = r.count;
          next_r.rdat[16] = r.cts;
          next_r.rdat[17] = r.paused;
          next_r.rdat[18] = r.rx_perr;
        end
        ADDR_BAUD: begin
          next_r.rdat[2:0] = r.baud;
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[2:0] <= BAUD_MAX) next_r.baud = wb_dat_i[2:0];
        end
        default: next_r.rdat = '0;
      endcase
    end

    // receiver: samples mid-bit
    next_r.rx_tick = (r.rx_tick == 17'h00000) ? 17'h00000 : r.rx_tick - 17'h00001;
    case (r.rx_st)
      RX_IDLE: if (!host_rxd_i) begin
        next_r.rx_st = RX_START;
        next_r.rx_tick = bdiv >> 1;
        next_r.rx_bit = 4'h0;
      end
      // a start bit gone by mid-bit was a glitch, not a character
      RX_START: if (r.rx_tick == 17'h00000) begin
        next_r.rx_tick = bdiv;
        next_r.rx_st = host_rxd_i ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (r.rx_tick == 17'h00000) begin
        next_r.rx_sh = {host_rxd_i, r.rx_sh[8:1]};
        next_r.rx_tick = bdiv;
        next_r.rx_bit = r.rx_bit + 4'h1;
        if (r.rx_bit == 4'h7) next_r.rx_st = has_par ? RX_PAR : RX_STOP;
      end
      RX_PAR: if (r.rx_tick == 17'h00000) begin
        if (r.parity != PAR_NINE)
          next_r.rx_perr = (host_rxd_i != par_bit(r.parity, r.rx_sh[8:1]));
        next_r.rx_tick = bdiv;
        next_r.rx_st = RX_STOP;
      end
      RX_STOP: if (r.rx_tick == 17'h00000) begin
        next_r.rx_st = RX_IDLE;
        // overflow drops the byte; cts should have held the host back
        if (host_rxd_i && r.count < CAP) push = 1'b1;
      end
      default: next_r.rx_st = RX_IDLE;
    endcase

    // silence timer restarts on any line activity
    if (r.rx_st != RX_IDLE || !host_rxd_i) begin
      next_r.unit_cnt = '0;
      next_r.quiet = '0;
    end else if (r.unit_cnt == 16'(SILENCE_UNIT - 1)) begin
      next_r.unit_cnt = '0;
      if (r.quiet != 16'hffff) next_r.quiet = r.quiet + 16'h0001;
    end else begin
      next_r.unit_cnt = r.unit_cnt + 16'h0001;
    end

    // packetizer
    next_r.rvalid = r.rvalid && !radio_ready_i;
    case (r.pk_st)
      PK_WAIT: if (r.count != '0 &&
          ((r.count >= (AW + 1)'(r.char_thr)) ||
           (r.silence != 16'h0000 && r.quiet >= r.silence))) begin
        next_r.pk_st = PK_SEND;
        next_r.pkt_cnt = 9'h000;
      end
      PK_SEND: if (!r.rvalid || radio_ready_i) begin
        if (r.count != '0) begin
          pop = 1'b1;
          next_r.rdata = mem[r.rp];
          next_r.rvalid = 1'b1;
          next_r.pkt_cnt = (r.pkt_cnt + 9'h001 >= r.max_pkt) ? 9'h000 : r.pkt_cnt + 9'h001;
          next_r.rlast = (r.pkt_cnt + 9'h001 >= r.max_pkt) || (r.count == (AW + 1)'(1));
          if (r.count == (AW + 1)'(1)) next_r.pk_st = PK_WAIT;
        end else begin
          next_r.pk_st = PK_WAIT;
        end
      end
      default: next_r.pk_st = PK_WAIT;
    endcase

    if (push) next_r.wp = r.wp + 1'b1;
    if (pop) next_r.rp = r.rp + 1'b1;
    next_r.count = r.count + (AW + 1)'(push) - (AW + 1)'(pop);

    // hardware and software flow control with hysteresis
    if (next_r.count >= r.flow_thr) begin
      next_r.cts = 1'b0;
      if (r.swflow && !r.paused) begin
        next_r.paused = 1'b1;
        next_r.pend_char = CHAR_PAUSE;
        next_r.pend = 1'b1;
      end
    end else if (next_r.count < restart) begin
      next_r.cts = 1'b1;
      if (r.paused) begin
        next_r.paused = 1'b0;
        next_r.pend_char = CHAR_RESUME;
        next_r.pend = r.swflow;
      end
    end

    // transmitter for flow characters only
    next_r.tx_tick = (r.tx_tick == 17'h00000) ? 17'h00000 : r.tx_tick - 17'h00001;
    if (r.tx_bit == 4'h0) begin
      next_r.txd = 1'b1;
      // the stop bit runs its full time before the next start
      if (r.pend && next_r.pend && r.tx_tick == 17'h00000 && !rts_hold) begin
        next_r.pend = 1'b0;
        next_r.tx_sh = {1'b1, r.pend_char, 1'b0};
        next_r.tx_bit = 4'ha;
        next_r.tx_tick = '0;
      end
    end else if (r.tx_tick == 17'h00000) begin
      next_r.txd = r.tx_sh[0];
      next_r.tx_sh = {1'b1, r.tx_sh[9:1]};
      next_r.tx_tick = bdiv;
      next_r.tx_bit = r.tx_bit - 4'h1;
    end

    // flow output pin: active-low cts by default
    case (r.outpin)
      3'h0: next_r.flow_pin = ~next_r.cts;
      3'h2: next_r.flow_pin = 1'b1;
      default: next_r.flow_pin = 1'b0;
    endcase
    next_r.bincmd = (r.inline_cfg == INLINE_BINCMD) && configurable_input_pin_i;
  end

  always_ff @(posedge clk_i) begin
    if (push) mem[r.wp] <= r.rx_sh[8:1];
    if (rst_i) begin
      r <= '0;
      r.swflow <= 1'b0;
      r.parity <= PAR_NONE;
      r.inline_cfg <= INLINE_OFF;
      r.flow_thr <= FT_MAX;
      r.max_pkt <= MAX_PKT_RST;
      r.char_thr <= CHAR_THR_RST;
      r.silence <= SILENCE_RST;
      r.baud <= BAUD_RST;
      r.cts <= 1'b1;
      r.txd <= 1'b1;
      r.rx_st <= RX_IDLE;
      r.pk_st <= PK_WAIT;
    end else begin
      r <= next_r;
    end
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdat;
  assign host_txd_o = r.txd;
  assign flow_output_pin_o = r.flow_pin;
  assign radio_data_o = r.rdata;
  assign radio_valid_o = r.rvalid;
  assign radio_last_o = r.rlast;
  assign binary_cmd_o = r.bincmd;
endmodule : hsp_top
`default_nettype wire
